// *** hw/iocr_pkg.sv ***
/*
  Constants for the I/O board configuration register bank: register
  addresses, field positions, reset values and timing figures.
  Assumes a 100 MHz core clock and a Modbus engine outside the bank.
*/
package iocr_pkg;

  // Register addresses as seen by the Modbus master
  localparam logic [15:0] A_DEVICE_TYPE = 16'h0100;
  localparam logic [15:0] A_FW_VERSION = 16'h0101;
  localparam logic [15:0] A_SERIAL_FIRST = 16'h0102;
  localparam logic [15:0] A_SERIAL_SECOND = 16'h0103;
  localparam logic [15:0] A_UNIT_REF = 16'h010E;
  localparam logic [15:0] A_INVERT_MAP = 16'h010F;
  localparam logic [15:0] A_POWER_ON_MASK = 16'h0110;
  localparam logic [15:0] A_LINK_CFG = 16'h0111;
  localparam logic [15:0] A_SLAVE_ADDR = 16'h0112;
  localparam logic [15:0] A_ANALOG_MODE = 16'h0113;
  localparam logic [15:0] A_CUT_TIMEOUT = 16'h0114;
  localparam logic [15:0] A_CUT_LENGTH = 16'h0115;

  // Reset values
  localparam logic [15:0] RST_UNIT_REF = 16'h0030;
  localparam logic [15:0] RST_LINK_CFG = 16'h0001;
  localparam logic [15:0] RST_SLAVE_ADDR = 16'h0001;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [7:0] RST_SERIAL = 8'h00;

  // Identity words, values arbitrary
  localparam logic [15:0] DEVICE_TYPE_ID = 16'h005A;
  localparam logic [15:0] FW_VERSION_ID = 16'h0001;

  // Field positions in the link configuration register
  localparam int BAUD_LO = 0;
  localparam int BAUD_HI = 2;
  localparam int DEBOUNCE_OFF_BIT = 3;
  localparam int STICKY_BIT = 4;
  localparam int WIEG_ONE_BIT = 5;
  localparam int WIEG_TWO_BIT = 6;
  localparam int PARITY_NONE_BIT = 7;

  // Field positions elsewhere
  localparam int UNIT_LO = 8;
  localparam int UNIT_HI = 15;
  localparam int REF_LO = 0;
  localparam int REF_HI = 7;
  localparam int OUT_LO = 8;
  localparam int OUT_HI = 11;
  localparam int BYTE_HI = 7;

  // Timing
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint SECOND_NS = 1000000000;
  localparam longint QUARTER_MS_NS = 250000;
  localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam int QUARTER_CYCLES = int'(QUARTER_MS_NS / CLK_PERIOD_NS);

  // Communication-loss power cut states
  typedef enum logic {CUT_IDLE, CUT_ACTIVE} iocr_cut_state_t;

  // Quarter milliseconds per pulse-output time unit
  function automatic logic [7:0] unit_quarters(input logic [7:0] code);
    unit_quarters = 8'h04;
    case (code)
      8'h01: unit_quarters = 8'h01;
      8'h02: unit_quarters = 8'h02;
      8'h04: unit_quarters = 8'h08;
      8'h05: unit_quarters = 8'h10;
      8'h06: unit_quarters = 8'h20;
      8'h07: unit_quarters = 8'h40;
      default: unit_quarters = 8'h04;
    endcase
  endfunction

endpackage

// *** hw/iocr_bank.sv ***
/*
  Configuration and identification register bank of a Modbus slave I/O
  board, with the communication-loss auxiliary power cut and the global
  pulse-output time base. Assumes the Modbus engine decodes frames and
  presents one register access at a time, and flags valid frames.
*/
`timescale 1ns/1ns

// Operation
// - Serial numbers: low byte, single write once
// - Upper unit byte selects pulse time unit
// - Lower unit byte selects analog reference
// - Inversion bitmap bit inverts its input
// - Mask bits 8-11 give output power-on states
// - Config bit 3 turns debounce off
// - Config bit 4 enables sticky inputs
// - Config bits 5,6 enable Wiegand receivers
// - Config bit 7 selects no parity
// - Codes 1,2,5 give 9600,19200,115200 baud
// - Link loss for timeout cuts aux power
// - Cut lasts pulse-length seconds, then restores
// - Zero timeout or length disables cut
module iocr_bank #(
  parameter int unsigned SEC_CYCLES = iocr_pkg::SECOND_CYCLES,
  parameter int unsigned QTR_CYCLES = iocr_pkg::QUARTER_CYCLES
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register access from the Modbus engine
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic REG_SINGLE,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_ACK,
  output logic REG_ERR,
  // Link activity
  input wire logic FRAME_OK,
  // Settings to the rest of the board
  output logic [7:0] PULSE_UNIT,
  output logic PULSE_UNIT_TICK,
  output logic [7:0] REF_CODE,
  output logic [15:0] INVERT_MAP,
  output logic [3:0] POWERON_OUT,
  output logic [2:0] BAUD_CODE,
  output logic PARITY_NONE,
  output logic DEBOUNCE_OFF,
  output logic STICKY_EN,
  output logic WIEG_ONE_EN,
  output logic WIEG_TWO_EN,
  output logic [7:0] SLAVE_ADDR,
  output logic [15:0] ANALOG_MODE,
  // Auxiliary 5V supply on both headers, and output restore strobe at cut start
  output logic AUX_POWER_ON,
  output logic OUT_RESTORE
);

  logic [7:0] sn_first_ff, nxt_sn_first, sn_second_ff, nxt_sn_second;
  logic sn_first_lock_ff, nxt_sn_first_lock, sn_second_lock_ff, nxt_sn_second_lock;
  logic [15:0] unit_ref_ff, nxt_unit_ref, invert_ff, nxt_invert;
  logic [15:0] mask_ff, nxt_mask, cfg_ff, nxt_cfg, addr_ff, nxt_addr;
  logic [15:0] amode_ff, nxt_amode, timeout_ff, nxt_timeout, length_ff, nxt_length;
  logic [15:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack, err_ff, nxt_err;
  logic [31:0] sec_ff, nxt_sec, qtr_ff, nxt_qtr;
  logic [15:0] loss_ff, nxt_loss, cutcnt_ff, nxt_cutcnt;
  logic [7:0] ucnt_ff, nxt_ucnt;
  logic utick_ff, nxt_utick, aux_ff, nxt_aux, restore_ff, nxt_restore;
  iocr_pkg::iocr_cut_state_t cut_ff, nxt_cut;
  logic sec_tick, qtr_tick, cut_en;

  // Register writes and reads, answered one cycle later
  always_comb begin
    nxt_sn_first = sn_first_ff;
    nxt_sn_second = sn_second_ff;
    nxt_sn_first_lock = sn_first_lock_ff;
    nxt_sn_second_lock = sn_second_lock_ff;
    nxt_unit_ref = unit_ref_ff;
    nxt_invert = invert_ff;
    nxt_mask = mask_ff;
    nxt_cfg = cfg_ff;
    nxt_addr = addr_ff;
    nxt_amode = amode_ff;
    nxt_timeout = timeout_ff;
    nxt_length = length_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = REG_WR | REG_RD;
    nxt_err = 1'b0;
    if (REG_WR) begin
      unique case (REG_ADDR)
        iocr_pkg::A_SERIAL_FIRST: begin
          if (REG_SINGLE && !sn_first_lock_ff) begin
            nxt_sn_first = REG_WDATA[iocr_pkg::BYTE_HI:0];
            nxt_sn_first_lock = 1'b1;
          end else begin
            nxt_err = 1'b1;
          end
        end
        iocr_pkg::A_SERIAL_SECOND: begin
          if (REG_SINGLE && !sn_second_lock_ff) begin
            nxt_sn_second = REG_WDATA[iocr_pkg::BYTE_HI:0];
            nxt_sn_second_lock = 1'b1;
          end else begin
            nxt_err = 1'b1;
          end
        end
        iocr_pkg::A_UNIT_REF: nxt_unit_ref = REG_WDATA;
        iocr_pkg::A_INVERT_MAP: nxt_invert = REG_WDATA;
        iocr_pkg::A_POWER_ON_MASK: nxt_mask = REG_WDATA;
        iocr_pkg::A_LINK_CFG: nxt_cfg = REG_WDATA;
        iocr_pkg::A_SLAVE_ADDR: nxt_addr = REG_WDATA;
        iocr_pkg::A_ANALOG_MODE: nxt_amode = REG_WDATA;
        iocr_pkg::A_CUT_TIMEOUT: nxt_timeout = REG_WDATA;
        iocr_pkg::A_CUT_LENGTH: nxt_length = REG_WDATA;
        default: nxt_err = 1'b1;
      endcase
    end else if (REG_RD) begin
      nxt_rdata = iocr_pkg::RST_ZERO;
      unique case (REG_ADDR)
        iocr_pkg::A_DEVICE_TYPE: nxt_rdata = iocr_pkg::DEVICE_TYPE_ID;
        iocr_pkg::A_FW_VERSION: nxt_rdata = iocr_pkg::FW_VERSION_ID;
        iocr_pkg::A_SERIAL_FIRST: nxt_rdata = {8'h00, sn_first_ff};
        iocr_pkg::A_SERIAL_SECOND: nxt_rdata = {8'h00, sn_second_ff};
        iocr_pkg::A_UNIT_REF: nxt_rdata = unit_ref_ff;
        iocr_pkg::A_INVERT_MAP: nxt_rdata = invert_ff;
        iocr_pkg::A_POWER_ON_MASK: nxt_rdata = mask_ff;
        iocr_pkg::A_LINK_CFG: nxt_rdata = cfg_ff;
        iocr_pkg::A_SLAVE_ADDR: nxt_rdata = addr_ff;
        iocr_pkg::A_ANALOG_MODE: nxt_rdata = amode_ff;
        iocr_pkg::A_CUT_TIMEOUT: nxt_rdata = timeout_ff;
        iocr_pkg::A_CUT_LENGTH: nxt_rdata = length_ff;
        default: nxt_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sn_first_ff <= iocr_pkg::RST_SERIAL;
      sn_second_ff <= iocr_pkg::RST_SERIAL;
      sn_first_lock_ff <= 1'b0;
      sn_second_lock_ff <= 1'b0;
      unit_ref_ff <= iocr_pkg::RST_UNIT_REF;
      invert_ff <= iocr_pkg::RST_ZERO;
      mask_ff <= iocr_pkg::RST_ZERO;
      cfg_ff <= iocr_pkg::RST_LINK_CFG;
      addr_ff <= iocr_pkg::RST_SLAVE_ADDR;
      amode_ff <= iocr_pkg::RST_ZERO;
      timeout_ff <= iocr_pkg::RST_ZERO;
      length_ff <= iocr_pkg::RST_ZERO;
      rdata_ff <= iocr_pkg::RST_ZERO;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      sn_first_ff <= nxt_sn_first;
      sn_second_ff <= nxt_sn_second;
      sn_first_lock_ff <= nxt_sn_first_lock;
      sn_second_lock_ff <= nxt_sn_second_lock;
      unit_ref_ff <= nxt_unit_ref;
      invert_ff <= nxt_invert;
      mask_ff <= nxt_mask;
      cfg_ff <= nxt_cfg;
      addr_ff <= nxt_addr;
      amode_ff <= nxt_amode;
      timeout_ff <= nxt_timeout;
      length_ff <= nxt_length;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
    end
  end

  // Setting outputs other than PULSE_UNIT_TICK are slices of the holding registers
  assign REG_RDATA = rdata_ff;
  assign REG_ACK = ack_ff;
  assign REG_ERR = err_ff;
  assign PULSE_UNIT = unit_ref_ff[iocr_pkg::UNIT_HI:iocr_pkg::UNIT_LO];
  assign REF_CODE = unit_ref_ff[iocr_pkg::REF_HI:iocr_pkg::REF_LO];
  assign INVERT_MAP = invert_ff;
  assign POWERON_OUT = mask_ff[iocr_pkg::OUT_HI:iocr_pkg::OUT_LO];
  assign BAUD_CODE = cfg_ff[iocr_pkg::BAUD_HI:iocr_pkg::BAUD_LO];
  assign DEBOUNCE_OFF = cfg_ff[iocr_pkg::DEBOUNCE_OFF_BIT];
  assign STICKY_EN = cfg_ff[iocr_pkg::STICKY_BIT];
  assign WIEG_ONE_EN = cfg_ff[iocr_pkg::WIEG_ONE_BIT];
  assign WIEG_TWO_EN = cfg_ff[iocr_pkg::WIEG_TWO_BIT];
  assign PARITY_NONE = cfg_ff[iocr_pkg::PARITY_NONE_BIT];
  assign SLAVE_ADDR = addr_ff[iocr_pkg::BYTE_HI:0];
  assign ANALOG_MODE = amode_ff;
  assign PULSE_UNIT_TICK = utick_ff;
  assign AUX_POWER_ON = aux_ff;
  assign OUT_RESTORE = restore_ff;

  // Second and quarter-millisecond strobes
  assign sec_tick = (sec_ff == SEC_CYCLES - 1);
  assign qtr_tick = (qtr_ff == QTR_CYCLES - 1);
  assign cut_en = (timeout_ff != iocr_pkg::RST_ZERO) && (length_ff != iocr_pkg::RST_ZERO);

  // Communication-loss watchdog and aux power cut
  always_comb begin
    nxt_sec = sec_tick ? 32'h0000_0000 : sec_ff + 32'h0000_0001;
    nxt_loss = loss_ff;
    nxt_cutcnt = cutcnt_ff;
    nxt_cut = cut_ff;
    nxt_restore = 1'b0;
    if (!cut_en) begin
      nxt_cut = iocr_pkg::CUT_IDLE;
      nxt_loss = iocr_pkg::RST_ZERO;
    end else begin
      unique case (cut_ff)
        iocr_pkg::CUT_IDLE: begin
          if (FRAME_OK) begin
            nxt_sec = 32'h0000_0000;
            nxt_loss = iocr_pkg::RST_ZERO;
          end else if (sec_tick) begin
            nxt_loss = loss_ff + 16'h0001;
            if (loss_ff + 16'h0001 >= timeout_ff) begin
              nxt_cut = iocr_pkg::CUT_ACTIVE;
              nxt_cutcnt = iocr_pkg::RST_ZERO;
              nxt_restore = 1'b1;
            end
          end
        end
        iocr_pkg::CUT_ACTIVE: begin
          if (sec_tick) begin
            nxt_cutcnt = cutcnt_ff + 16'h0001;
            if (cutcnt_ff + 16'h0001 >= length_ff) begin
              nxt_cut = iocr_pkg::CUT_IDLE;
              nxt_loss = iocr_pkg::RST_ZERO;
            end
          end
        end
      endcase
    end
    nxt_aux = (nxt_cut == iocr_pkg::CUT_IDLE);
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sec_ff <= 32'h0000_0000;
      loss_ff <= iocr_pkg::RST_ZERO;
      cutcnt_ff <= iocr_pkg::RST_ZERO;
      cut_ff <= iocr_pkg::CUT_IDLE;
      aux_ff <= 1'b1;
      restore_ff <= 1'b0;
    end else begin
      sec_ff <= nxt_sec;
      loss_ff <= nxt_loss;
      cutcnt_ff <= nxt_cutcnt;
      cut_ff <= nxt_cut;
      aux_ff <= nxt_aux;
      restore_ff <= nxt_restore;
    end
  end

  // Global pulse-output time unit strobe
  always_comb begin
    nxt_qtr = qtr_tick ? 32'h0000_0000 : qtr_ff + 32'h0000_0001;
    nxt_ucnt = ucnt_ff;
    nxt_utick = 1'b0;
    if (qtr_tick) begin
      if (ucnt_ff + 8'h01 >= iocr_pkg::unit_quarters(PULSE_UNIT)) begin
        nxt_ucnt = 8'h00;
        nxt_utick = 1'b1;
      end else begin
        nxt_ucnt = ucnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      qtr_ff <= 32'h0000_0000;
      ucnt_ff <= 8'h00;
      utick_ff <= 1'b0;
    end else begin
      qtr_ff <= nxt_qtr;
      ucnt_ff <= nxt_ucnt;
      utick_ff <= nxt_utick;
    end
  end

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_sn_locked_write;
    REG_WR && (REG_ADDR == iocr_pkg::A_SERIAL_FIRST) && sn_first_lock_ff;
  endsequence
  sequence s_loss_expire;
    (cut_ff == iocr_pkg::CUT_IDLE) && cut_en && sec_tick && !FRAME_OK
      && (loss_ff + 16'h0001 >= timeout_ff);
  endsequence
  sequence s_cut_expire;
    (cut_ff == iocr_pkg::CUT_ACTIVE) && cut_en && sec_tick
      && (cutcnt_ff + 16'h0001 >= length_ff);
  endsequence

  a_sn_write_once: assert property (
    s_sn_locked_write |=> (sn_first_ff == $past(sn_first_ff)) && REG_ERR)
    else $error("serial number changed after lock");
  a_sn_multi_refused: assert property (
    REG_WR && !REG_SINGLE && (REG_ADDR == iocr_pkg::A_SERIAL_SECOND)
      |=> $stable(sn_second_ff) && REG_ERR)
    else $error("multi-register serial write accepted");
  a_unit_ref_store: assert property (
    REG_WR && (REG_ADDR == iocr_pkg::A_UNIT_REF)
      |=> (PULSE_UNIT == $past(REG_WDATA[15:8])) && (REF_CODE == $past(REG_WDATA[7:0])))
    else $error("unit or reference not stored");
  a_invert_store: assert property (
    REG_WR && (REG_ADDR == iocr_pkg::A_INVERT_MAP) |=> INVERT_MAP == $past(REG_WDATA))
    else $error("inversion map not stored");
  a_poweron_bits: assert property (
    REG_WR && (REG_ADDR == iocr_pkg::A_POWER_ON_MASK)
      |=> POWERON_OUT == $past(REG_WDATA[11:8]))
    else $error("power-on outputs not from bits 8 to 11");
  a_link_cfg_fields: assert property (
    REG_WR && (REG_ADDR == iocr_pkg::A_LINK_CFG)
      |=> ({PARITY_NONE, WIEG_TWO_EN, WIEG_ONE_EN, STICKY_EN, DEBOUNCE_OFF, BAUD_CODE}
        == $past(REG_WDATA[7:0])))
    else $error("link configuration fields wrong");
  a_cut_start: assert property (
    s_loss_expire |=> !AUX_POWER_ON && OUT_RESTORE ##1 !OUT_RESTORE)
    else $error("power not cut on link loss");
  a_cut_restore: assert property (
    s_cut_expire |=> AUX_POWER_ON)
    else $error("power not restored after cut length");
  a_cut_disabled: assert property (
    !cut_en |=> AUX_POWER_ON)
    else $error("power cut while disabled");
  a_frame_restart: assert property (
    (cut_ff == iocr_pkg::CUT_IDLE) && cut_en && FRAME_OK
      |=> (loss_ff == 16'h0000) && (sec_ff == 32'h0000_0000))
    else $error("frame did not restart loss timer");

endmodule

// *** testbench/iocr_master_model.sv ***
/*
  Modbus master stand-in: issues register accesses and valid-frame marks
  to the bank, and queues the answer each access should get.
  Assumes the bench watcher pops the queue on every acknowledge.
*/
`timescale 1ns/1ns

module iocr_master_model (
  // Clock
  input wire logic MCLK,
  // Register access
  output logic REG_WR,
  output logic REG_RD,
  output logic REG_SINGLE,
  output logic [15:0] REG_ADDR,
  output logic [15:0] REG_WDATA,
  // Link activity
  output logic FRAME_OK
);
  // Expected answers: {is_read, err, data}
  logic [17:0] exp_q[$];

  // Idle bus at time zero
  initial begin
    {REG_WR, REG_RD, REG_SINGLE, FRAME_OK} = 4'h0;
    REG_ADDR = 16'h0000;
    REG_WDATA = 16'h0000;
  end

  // One access, held through the taking edge, then released
  task automatic access(input logic wr, input logic single, input logic [15:0] addr,
                        input logic [15:0] data, input logic err);
    @(posedge MCLK);
    #1;
    REG_WR = wr;
    REG_RD = !wr;
    REG_SINGLE = single;
    REG_ADDR = addr;
    REG_WDATA = data;
    exp_q.push_back({!wr, err, data});
    @(posedge MCLK);
    #1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    // Released lines carry no stale value
    REG_ADDR = ~addr;
    REG_WDATA = ~data;
  endtask

  // Address writes only within 1..247, analog mode never written
  function automatic logic [15:0] legal_addr(input logic [15:0] r);
    legal_addr = 16'h0001 + (r % 16'h00F7);
  endfunction

  // One valid frame addressed to the board
  task automatic frame();
    @(posedge MCLK);
    #1;
    FRAME_OK = 1'b1;
    @(posedge MCLK);
    #1;
    FRAME_OK = 1'b0;
  endtask
endmodule

// *** testbench/io_module_config_registers_tb.sv ***
/*
  Self-checking bench for the configuration register bank.
  Assumes shortened second and quarter-millisecond counts.
*/
`timescale 1ns/1ns

module io_module_config_registers_tb;
  localparam int SEC = 20;
  localparam int QTR = 4;
  logic MCLK, RST_N, REG_WR, REG_RD, REG_SINGLE, FRAME_OK, REG_ACK, REG_ERR;
  logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, INVERT_MAP, ANALOG_MODE;
  logic [7:0] PULSE_UNIT, REF_CODE, SLAVE_ADDR;
  logic [3:0] POWERON_OUT;
  logic [2:0] BAUD_CODE;
  logic PULSE_UNIT_TICK, PARITY_NONE, DEBOUNCE_OFF, STICKY_EN, WIEG_ONE_EN, WIEG_TWO_EN;
  logic AUX_POWER_ON, OUT_RESTORE;
  int miscompares = 0;
  int check_count = 0;
  logic [31:0] seed = 32'd46688;
  logic [17:0] exp_ans;
  logic [7:0] cfg_tab[6] = '{8'h01, 8'h02, 8'h05, 8'h81, 8'h82, 8'h85};
  int quarters[8] = '{4, 1, 2, 4, 8, 16, 32, 64};
  int n;
  logic [15:0] v;

  iocr_master_model mst (.MCLK(MCLK), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_SINGLE(REG_SINGLE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .FRAME_OK(FRAME_OK));

  iocr_bank #(.SEC_CYCLES(SEC), .QTR_CYCLES(QTR)) dut (.MCLK(MCLK), .RST_N(RST_N),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_SINGLE(REG_SINGLE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_ERR(REG_ERR),
    .FRAME_OK(FRAME_OK), .PULSE_UNIT(PULSE_UNIT), .PULSE_UNIT_TICK(PULSE_UNIT_TICK),
    .REF_CODE(REF_CODE), .INVERT_MAP(INVERT_MAP), .POWERON_OUT(POWERON_OUT),
    .BAUD_CODE(BAUD_CODE), .PARITY_NONE(PARITY_NONE), .DEBOUNCE_OFF(DEBOUNCE_OFF),
    .STICKY_EN(STICKY_EN), .WIEG_ONE_EN(WIEG_ONE_EN), .WIEG_TWO_EN(WIEG_TWO_EN),
    .SLAVE_ADDR(SLAVE_ADDR), .ANALOG_MODE(ANALOG_MODE), .AUX_POWER_ON(AUX_POWER_ON),
    .OUT_RESTORE(OUT_RESTORE));

  // Clock, 10 ns period
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    rnd = seed[15:0];
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    check(16'(mst.exp_q.size()), 16'h0000, "unanswered accesses");
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Sample one cycle later, settled
  task automatic step();
    @(posedge MCLK);
    #1;
  endtask

  // Bounded wait for the power output to reach a level
  task automatic wait_aux(input logic lvl, output int cnt);
    cnt = 0;
    while (AUX_POWER_ON !== lvl && cnt < 2000) begin
      step();
      cnt++;
    end
    if (cnt >= 2000) begin
      check(16'h0000, 16'h0001, "aux wait limit");
      report_and_stop();
    end
  endtask

  task automatic wait_tick(output int cnt);
    cnt = 0;
    do begin
      step();
      cnt++;
    end while (PULSE_UNIT_TICK !== 1'b1 && cnt < 1000);
    if (cnt >= 1000) begin
      check(16'h0000, 16'h0001, "tick wait limit");
      report_and_stop();
    end
  endtask

  // Answer watcher: oldest queued note against each acknowledge
  always @(negedge MCLK) begin
    if (REG_ACK === 1'b1) begin
      exp_ans = (mst.exp_q.size() > 0) ? mst.exp_q.pop_front() : 18'h3FFFF;
      check_count++;
      if (REG_ERR !== exp_ans[16] || (exp_ans[17] && REG_RDATA !== exp_ans[15:0])) begin
        miscompares++;
        $display("unexpected %0t: answer %h err %b", $time, REG_RDATA, REG_ERR);
      end
    end
  end

  initial begin
    RST_N = 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    RST_N = 1'b1;
    // Power cut disabled by zero settings, then cut, restored, and held off by traffic
    repeat (100) step();
    check(16'(AUX_POWER_ON), 16'h0001, "aux with zero settings");
    mst.access(1'b1, 1'b1, iocr_pkg::A_CUT_TIMEOUT, 16'h0002, 1'b0);
    repeat (100) step();
    check(16'(AUX_POWER_ON), 16'h0001, "aux with zero length");
    mst.access(1'b1, 1'b1, iocr_pkg::A_CUT_LENGTH, 16'h0001, 1'b0);
    mst.frame();
    wait_aux(1'b0, n);
    check(16'(n >= 2 * SEC - 2 && n <= 2 * SEC + 2), 16'h0001, "cut delay");
    check(16'(OUT_RESTORE), 16'h0001, "restore pulse");
    mst.frame();
    wait_aux(1'b1, n);
    check(16'(n + 2), 16'(SEC), "cut length");
    repeat (5) begin
      mst.frame();
      repeat (28) begin
        step();
        check(16'(AUX_POWER_ON), 16'h0001, "aux with traffic");
      end
    end
    $display("test watchdog done");
    // Identity, reset values, refusals
    mst.access(1'b0, 1'b0, iocr_pkg::A_DEVICE_TYPE, iocr_pkg::DEVICE_TYPE_ID, 1'b0);
    mst.access(1'b0, 1'b0, iocr_pkg::A_FW_VERSION, iocr_pkg::FW_VERSION_ID, 1'b0);
    mst.access(1'b1, 1'b1, iocr_pkg::A_DEVICE_TYPE, 16'h1234, 1'b1);
    mst.access(1'b0, 1'b0, 16'h0104, 16'h0000, 1'b1);
    mst.access(1'b0, 1'b0, iocr_pkg::A_UNIT_REF, 16'h0030, 1'b0);
    mst.access(1'b0, 1'b0, iocr_pkg::A_ANALOG_MODE, 16'h0000, 1'b0);
    check(ANALOG_MODE, 16'h0000, "analog mode output");
    check(16'(SLAVE_ADDR), 16'h0001, "address reset");
    check(16'(BAUD_CODE), 16'h0001, "baud reset");
    // Serial numbers: single write only, once, low byte
    mst.access(1'b1, 1'b0, iocr_pkg::A_SERIAL_FIRST, 16'hABCD, 1'b1);
    mst.access(1'b1, 1'b1, iocr_pkg::A_SERIAL_FIRST, 16'hABCD, 1'b0);
    mst.access(1'b1, 1'b1, iocr_pkg::A_SERIAL_FIRST, 16'h0011, 1'b1);
    mst.access(1'b0, 1'b0, iocr_pkg::A_SERIAL_FIRST, 16'h00CD, 1'b0);
    mst.access(1'b1, 1'b0, iocr_pkg::A_SERIAL_SECOND, 16'h1234, 1'b1);
    mst.access(1'b1, 1'b1, iocr_pkg::A_SERIAL_SECOND, 16'h5A3C, 1'b0);
    mst.access(1'b0, 1'b0, iocr_pkg::A_SERIAL_SECOND, 16'h003C, 1'b0);
    $display("test identity done");
    // Every time unit code, with tick period in quarters
    for (int c = 0; c < 8; c++) begin
      mst.access(1'b1, 1'b1, iocr_pkg::A_UNIT_REF, {8'(c), 8'h20}, 1'b0);
      check(16'(PULSE_UNIT), 16'(c), "unit code");
      check(16'(REF_CODE), 16'h0020, "reference code");
      repeat (2) wait_tick(n);
      wait_tick(n);
      check(16'(n), 16'(quarters[c] * QTR), "tick period");
    end
    $display("test time unit done");
    // Random inversion map, power-on mask, address
    repeat (4) begin
      v = rnd();
      mst.access(1'b1, 1'b1, iocr_pkg::A_INVERT_MAP, v, 1'b0);
      check(INVERT_MAP, v, "inversion map");
      mst.access(1'b0, 1'b0, iocr_pkg::A_INVERT_MAP, v, 1'b0);
      v = rnd();
      mst.access(1'b1, 1'b1, iocr_pkg::A_POWER_ON_MASK, v, 1'b0);
      check(16'(POWERON_OUT), 16'(v[11:8]), "power-on outputs");
      v = mst.legal_addr(rnd());
      mst.access(1'b1, 1'b1, iocr_pkg::A_SLAVE_ADDR, v, 1'b0);
      check(16'(SLAVE_ADDR), v, "slave address");
    end
    // Link configuration: documented codes, then random bytes
    for (int i = 0; i < 12; i++) begin
      v = (i < 6) ? 16'(cfg_tab[i]) : (rnd() & 16'h00FF);
      mst.access(1'b1, 1'b1, iocr_pkg::A_LINK_CFG, v, 1'b0);
      check(16'(BAUD_CODE), 16'(v[2:0]), "baud code");
      check(16'(DEBOUNCE_OFF), 16'(v[3]), "debounce off");
      check(16'(STICKY_EN), 16'(v[4]), "sticky");
      check(16'({WIEG_TWO_EN, WIEG_ONE_EN}), 16'(v[6:5]), "wiegand");
      check(16'(PARITY_NONE), 16'(v[7]), "parity none");
      mst.access(1'b0, 1'b0, iocr_pkg::A_LINK_CFG, v, 1'b0);
    end
    $display("test configuration done");
    repeat (3) step();
    report_and_stop();
  end
endmodule
